/* hdl/smt_pkg.sv */
// package: register map, field positions and timing constants of the timeout detector
package smt_pkg;

   // ==========================================================
   // register indices on the plain register port
   localparam logic [3:0] ADDR_CONTROL     = 4'h0;
   localparam logic [3:0] ADDR_STATUS      = 4'h1;
   localparam logic [3:0] ADDR_DATA_LIMIT  = 4'h2;
   localparam logic [3:0] ADDR_CLOCK_LIMIT = 4'h3;
   localparam logic [3:0] ADDR_MSTR_LIMIT  = 4'h4;
   localparam logic [3:0] ADDR_SLV_LIMIT   = 4'h5;
   localparam logic [3:0] ADDR_BUS_CTRL    = 4'h6;

   // ==========================================================
   // timeout_control fields
   localparam int CTL_AAC  = 6;
   localparam int CTL_TEST = 5;
   localparam int CTL_TOE  = 4;
   localparam int CTL_EXT  = 3;
   localparam int CTL_TS_H = 2;
   localparam int CTL_TS_L = 0;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] CONTROL_MASK  = 8'h7F;

   // ==========================================================
   // timeout_status fields
   localparam int ST_DATA  = 3;
   localparam int ST_CLOCK = 2;
   localparam int ST_MSTR  = 1;
   localparam int ST_SLV   = 0;
   localparam logic [3:0] STATUS_RESET = 4'h0;

   // ==========================================================
   // bus control fields: error and transfer flags with enables
   localparam int BC_BER  = 3;
   localparam int BC_BUS_ERROR_IRQ_ENABLE = 2;
   localparam int BC_TRANSFER_DONE_IRQ_ENABLE = 1;
   localparam int BC_INT  = 0;
   localparam logic [3:0] BUS_CTRL_RESET = 4'h0;
   localparam logic [7:0] LIMIT_RESET    = 8'hFF;

   // ==========================================================
   // timing: base tick is T half instruction cycles times 10
   localparam int HALF_CYCLE_CLKS = 1;
   localparam int BASE_DIV        = 10;
   localparam int LINE_DIV        = 20;
   localparam int MSTR_DIV        = 10;
   localparam logic [2:0] TS_OFF  = 3'b000;

endpackage

/* hdl/smt_base_tick.sv */
// module: timeout base tick generator, T half cycles times 10
`timescale 1ns/10ps
`default_nettype none
module smt_base_tick
   import smt_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   // selection
   input  wire logic [2:0] sel,
   // tick out
   output logic            tick
);
   // ==========================================================
   // state
   typedef struct packed {
      logic [2:0] pre;
      logic [3:0] dec;
      logic       tick;
   } smt_tick_s;

   smt_tick_s cur;
   smt_tick_s next_cur;

   always_comb begin
      next_cur      = cur;
      next_cur.tick = 1'b0;
      if (sel == TS_OFF) begin                                // [RULE5]
         next_cur.pre = 3'h0;
         next_cur.dec = 4'h0;
      end else if (cur.pre >= sel - 3'h1) begin               // [RULE6]
         next_cur.pre = 3'h0;
         if (cur.dec == 4'(BASE_DIV - 1)) begin               // [RULE5]
            next_cur.dec  = 4'h0;
            next_cur.tick = 1'b1;
         end else begin
            next_cur.dec = cur.dec + 4'h1;
         end
      end else begin
         next_cur.pre = cur.pre + 3'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cur <= '0;
      end else if (ce) begin
         cur <= next_cur;
      end
   end

   assign tick = cur.tick;
endmodule // smt_base_tick
`default_nettype wire

/* hdl/smt_low_counter.sv */
// module: divided low-time counter with limit-plus-one match
`timescale 1ns/10ps
`default_nettype none
module smt_low_counter
   import smt_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   // control
   input  wire logic       tick,
   input  wire logic       run,
   input  wire logic       clear,
   input  wire logic       div20,
   input  wire logic [7:0] limit,
   // result
   output logic            hit
);
   // ==========================================================
   // state
   typedef struct packed {
      logic [4:0] div;
      logic [8:0] cnt;
      logic       hit;
   } smt_cnt_s;

   smt_cnt_s cur;
   smt_cnt_s next_cur;
   logic [4:0] div_top;

   always_comb begin
      div_top      = div20 ? 5'(LINE_DIV - 1) : 5'(MSTR_DIV - 1);
      next_cur     = cur;
      next_cur.hit = 1'b0;
      if (clear) begin
         next_cur.div = 5'h0;
         next_cur.cnt = 9'h000;
      end else if (run && tick) begin
         if (cur.div >= div_top) begin
            next_cur.div = 5'h0;
            next_cur.cnt = cur.cnt + 9'h001;
            if (cur.cnt + 9'h001 == {1'b0, limit} + 9'h001) begin
               next_cur.hit = 1'b1;
            end
         end else begin
            next_cur.div = cur.div + 5'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cur <= '0;
      end else if (ce) begin
         cur <= next_cur;
      end
   end

   assign hit = cur.hit;
endmodule // smt_low_counter
`default_nettype wire

/* hdl/smt_timeout_detector.sv */
// module: SMBus timeout detector with register port and interrupt lines
// Function
// RULE1 - auto_addr_ack 1 acknowledges matching address; 0 gives no address ack
// RULE2 - software writes 1 to control bit 5 though it resets to 0
// RULE3 - timeout_irq_enable gates timeout request; flags still set
// RULE4 - idle monitor lets detection run outside master or slave mode
// RULE5 - select 000 disables detection; base tick is T half cycles times 10
// RULE6 - select codes 1 to 7 are linear multipliers of half cycle
// RULE7 - data-line timeout sets status bit 3 and may request irq
// RULE8 - clock-line timeout sets status bit 2 and may request irq
// RULE9 - master timeout sets status bit 1 and may request irq
// RULE10 - slave timeout sets status bit 0 and may request irq
// RULE11 - writing 1 to a timeout status flag leaves it unchanged
// RULE12 - software clears a handled timeout flag by writing 0
// RULE13 - data counter counts while pin low, clears high, matches limit plus one
// RULE14 - data counter advances on base tick divided by 20
// RULE15 - clock counter counts while low, divided by 20, matches limit plus one
// RULE16 - master counter accumulates low time, clears on start ack stop exit
// RULE17 - master counter advances on base tick divided by 10
// RULE18 - slave counter accumulates low time by 20, clears on start stop exit
// RULE19 - bus error on stop in master mode or start/stop inside a byte
// RULE20 - bus error flag always sets; irq only with enable; write 0 clears
// RULE21 - transfer done flag always sets; irq only with enable; write 0 clears
// RULE22 - timeout expiry drives separate timeout irq line when enabled
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module smt_timeout_detector
   import smt_pkg::*;
(
   // clock, reset, enable
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   // register port
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   // bus lines, sampled
   input  wire logic       data_line_pin,
   input  wire logic       clock_line_pin,
   // events from the byte engine
   input  wire logic       master_mode,
   input  wire logic       slave_mode,
   input  wire logic       start_seen,
   input  wire logic       stop_seen,
   input  wire logic       ack_seen,
   input  wire logic       in_byte,
   input  wire logic       addr_match,
   input  wire logic       transfer_done,
   // outputs to byte engine and cpu
   output logic            addr_ack,
   output logic            bus_halt,
   output logic            transfer_irq_line,
   output logic            bus_error_irq,
   output logic            timeout_irq_line
);
   // ==========================================================
   // state
   typedef struct packed {
      logic [7:0] control;
      logic [3:0] status;
      logic [7:0] data_low_limit;
      logic [7:0] clock_low_limit;
      logic [7:0] master_low_limit;
      logic [7:0] slave_low_limit;
      logic [3:0] bus_ctrl;
      logic [7:0] rdata;
      logic       mstr_q;
      logic       slv_q;
   } smt_state_s;

   smt_state_s cur;
   smt_state_s next_cur;

   logic       tick;
   logic       det_on;
   logic       hit_data;
   logic       hit_clock;
   logic       hit_mstr;
   logic       hit_slv;
   logic [2:0] sel;
   logic       clr_mstr;
   logic       clr_slv;
   logic       bus_err;
   logic       st_wr;
   logic       bc_wr;

   // ==========================================================
   // detection enable and counter clears
   assign sel      = cur.control[CTL_TS_H:CTL_TS_L];
   assign det_on   = (sel != TS_OFF) &&
                     (cur.control[CTL_EXT] ||
                      master_mode || slave_mode);              // [RULE4]
   assign clr_mstr = start_seen || ack_seen || stop_seen ||
                     !master_mode || (cur.mstr_q && !master_mode); // [RULE16]
   assign clr_slv  = start_seen || stop_seen || !slave_mode ||
                     (cur.slv_q && !slave_mode);               // [RULE18]
   assign bus_err  = (stop_seen && master_mode) ||
                     ((start_seen || stop_seen) && in_byte);  // [RULE19]

   // ==========================================================
   // base tick and the four counters
   smt_base_tick u_tick (
      .clk  (clk),
      .rst  (rst),
      .ce   (ce),
      .sel  (sel),
      .tick (tick)
   );

   smt_low_counter u_data (
      .clk   (clk),
      .rst   (rst),
      .ce    (ce),
      .tick  (tick),
      .run   (det_on && !data_line_pin),                      // [RULE13]
      .clear (!det_on || data_line_pin),                      // [RULE13]
      .div20 (1'b1),                                          // [RULE14]
      .limit (cur.data_low_limit),
      .hit   (hit_data)
   );

   smt_low_counter u_clock (
      .clk   (clk),
      .rst   (rst),
      .ce    (ce),
      .tick  (tick),
      .run   (det_on && !clock_line_pin),                     // [RULE15]
      .clear (!det_on || clock_line_pin),                     // [RULE15]
      .div20 (1'b1),                                          // [RULE15]
      .limit (cur.clock_low_limit),
      .hit   (hit_clock)
   );

   smt_low_counter u_mstr (
      .clk   (clk),
      .rst   (rst),
      .ce    (ce),
      .tick  (tick),
      .run   (det_on && !clock_line_pin),                     // [RULE16]
      .clear (!det_on || clr_mstr),                           // [RULE16]
      .div20 (1'b0),                                          // [RULE17]
      .limit (cur.master_low_limit),
      .hit   (hit_mstr)
   );

   smt_low_counter u_slv (
      .clk   (clk),
      .rst   (rst),
      .ce    (ce),
      .tick  (tick),
      .run   (det_on && !clock_line_pin),                     // [RULE18]
      .clear (!det_on || clr_slv),                            // [RULE18]
      .div20 (1'b1),                                          // [RULE18]
      .limit (cur.slave_low_limit),
      .hit   (hit_slv)
   );

   // ==========================================================
   // register writes, flag updates, read data
   assign st_wr = reg_wr && (reg_addr == ADDR_STATUS);
   assign bc_wr = reg_wr && (reg_addr == ADDR_BUS_CTRL);

   always_comb begin
      next_cur        = cur;
      next_cur.mstr_q = master_mode;
      next_cur.slv_q  = slave_mode;
      if (reg_wr) begin
         case (reg_addr)
            ADDR_CONTROL:     next_cur.control = reg_wdata & CONTROL_MASK;
            ADDR_DATA_LIMIT:  next_cur.data_low_limit = reg_wdata;
            ADDR_CLOCK_LIMIT: next_cur.clock_low_limit = reg_wdata;
            ADDR_MSTR_LIMIT:  next_cur.master_low_limit = reg_wdata;
            ADDR_SLV_LIMIT:   next_cur.slave_low_limit = reg_wdata;
            default:          next_cur.control = cur.control;
         endcase
      end
      // writing 0 clears, writing 1 keeps the flag
      if (st_wr) begin
         next_cur.status = cur.status & reg_wdata[3:0];      // [RULE11]
      end
      // set wins over clear
      if (hit_data) begin
         next_cur.status[ST_DATA] = 1'b1;                     // [RULE7]
      end
      if (hit_clock) begin
         next_cur.status[ST_CLOCK] = 1'b1;                    // [RULE8]
      end
      if (hit_mstr) begin
         next_cur.status[ST_MSTR] = 1'b1;                     // [RULE9]
      end
      if (hit_slv) begin
         next_cur.status[ST_SLV] = 1'b1;                      // [RULE10]
      end
      if (bc_wr) begin
         next_cur.bus_ctrl[BC_BUS_ERROR_IRQ_ENABLE] = reg_wdata[BC_BUS_ERROR_IRQ_ENABLE];
         next_cur.bus_ctrl[BC_TRANSFER_DONE_IRQ_ENABLE] = reg_wdata[BC_TRANSFER_DONE_IRQ_ENABLE];
         next_cur.bus_ctrl[BC_BER]  = cur.bus_ctrl[BC_BER] &
                                      reg_wdata[BC_BER];      // [RULE20]
         next_cur.bus_ctrl[BC_INT]  = cur.bus_ctrl[BC_INT] &
                                      reg_wdata[BC_INT];      // [RULE21]
      end
      if (bus_err) begin
         next_cur.bus_ctrl[BC_BER] = 1'b1;                    // [RULE20]
      end
      if (transfer_done) begin
         next_cur.bus_ctrl[BC_INT] = 1'b1;                    // [RULE21]
      end
      next_cur.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_CONTROL:     next_cur.rdata = cur.control;
            ADDR_STATUS:      next_cur.rdata = {4'h0, cur.status};
            ADDR_DATA_LIMIT:  next_cur.rdata = cur.data_low_limit;
            ADDR_CLOCK_LIMIT: next_cur.rdata = cur.clock_low_limit;
            ADDR_MSTR_LIMIT:  next_cur.rdata = cur.master_low_limit;
            ADDR_SLV_LIMIT:   next_cur.rdata = cur.slave_low_limit;
            ADDR_BUS_CTRL:    next_cur.rdata = {4'h0, cur.bus_ctrl};
            default:          next_cur.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cur.control          <= CONTROL_RESET;
         cur.status           <= STATUS_RESET;
         cur.data_low_limit   <= LIMIT_RESET;
         cur.clock_low_limit  <= LIMIT_RESET;
         cur.master_low_limit <= LIMIT_RESET;
         cur.slave_low_limit  <= LIMIT_RESET;
         cur.bus_ctrl         <= BUS_CTRL_RESET;
         cur.rdata            <= 8'h00;
         cur.mstr_q           <= 1'b0;
         cur.slv_q            <= 1'b0;
      end else if (ce) begin
         cur <= next_cur;
      end
   end

   // ==========================================================
   // outputs
   assign reg_rdata = cur.rdata;
   assign addr_ack  = cur.control[CTL_AAC] && addr_match;     // [RULE1]
   assign bus_halt  = cur.bus_ctrl[BC_BER];                   // [RULE19]
   assign bus_error_irq = cur.bus_ctrl[BC_BER] &&
                          cur.bus_ctrl[BC_BUS_ERROR_IRQ_ENABLE];              // [RULE20]
   assign transfer_irq_line = cur.bus_ctrl[BC_INT] &&
                              cur.bus_ctrl[BC_TRANSFER_DONE_IRQ_ENABLE];          // [RULE21]
   assign timeout_irq_line = cur.control[CTL_TOE] &&
                             (sel != TS_OFF) &&
                             (cur.status != 4'h0);            // [RULE3] [RULE22]
endmodule // smt_timeout_detector
`default_nettype wire

/* bench/smt_properties.sv */
// checker: concurrent properties on the timeout detector ports
`timescale 1ns/10ps
`default_nettype none
module smt_props
   import smt_pkg::*;
(
   // clock, reset, enable
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       ce,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // bus lines and byte engine events
   input wire logic       data_line_pin,
   input wire logic       clock_line_pin,
   input wire logic       master_mode,
   input wire logic       slave_mode,
   input wire logic       start_seen,
   input wire logic       stop_seen,
   input wire logic       ack_seen,
   input wire logic       in_byte,
   input wire logic       addr_match,
   input wire logic       transfer_done,
   // outputs
   input wire logic       addr_ack,
   input wire logic       bus_halt,
   input wire logic       transfer_irq_line,
   input wire logic       bus_error_irq,
   input wire logic       timeout_irq_line
);
   // ==========================================================
   // shadow of software-written control and enables
   logic [7:0] ctl_sh;
   logic [3:0] bc_sh;
   always_ff @(posedge clk) begin
      if (rst) begin
         ctl_sh <= 8'h00;
         bc_sh  <= 4'h0;
      end else if (ce && reg_wr && reg_addr == ADDR_CONTROL) begin
         ctl_sh <= reg_wdata & CONTROL_MASK;
      end else if (ce && reg_wr && reg_addr == ADDR_BUS_CTRL) begin
         bc_sh <= reg_wdata[3:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ==========================================================
   // properties
   a_addr_ack_gate: assert property (
      addr_ack == (ctl_sh[CTL_AAC] && addr_match))
      else $error("address ack mismatch");
   a_timeout_irq_gate: assert property (
      timeout_irq_line |-> ctl_sh[CTL_TOE] && ctl_sh[2:0] != TS_OFF)
      else $error("timeout irq without enable");
   a_halt_master_stop: assert property (
      ce && stop_seen && master_mode |=> bus_halt)
      else $error("no halt on stop in master mode");
   a_halt_in_byte: assert property (
      ce && in_byte && (start_seen || stop_seen) |=> bus_halt)
      else $error("no halt on condition inside byte");
   a_error_irq_gate: assert property (
      bus_error_irq == (bus_halt && bc_sh[BC_BUS_ERROR_IRQ_ENABLE]))
      else $error("bus error irq mismatch");
   a_xfer_irq_gate: assert property (
      transfer_irq_line |-> bc_sh[BC_TRANSFER_DONE_IRQ_ENABLE])
      else $error("transfer irq without enable");
   a_xfer_irq_set: assert property (
      ce && transfer_done && bc_sh[BC_TRANSFER_DONE_IRQ_ENABLE] && !reg_wr |=> transfer_irq_line)
      else $error("transfer irq missing");
   a_control_readback: assert property (
      ce && reg_rd && reg_addr == ADDR_CONTROL |=> reg_rdata == ctl_sh)
      else $error("control readback mismatch");
   c_halt: cover property (bus_halt);
   c_timeout_irq: cover property (timeout_irq_line);
   c_xfer_irq: cover property (transfer_irq_line);
endmodule // smt_props
`default_nettype wire

/* bench/smt_bus_agent.sv */
// model: other bus agents holding or clocking the lines
`timescale 1ns/10ps
`default_nettype none
module smt_bus_agent (
   // clock
   input  wire logic clk,
   // commands
   input  wire logic data_low,
   input  wire logic clk_low,
   input  wire logic clk_toggle,
   // lines, pulled up when released
   output logic      data_line_pin,
   output logic      clock_line_pin
);
   logic [5:0] phase = 6'h00;
   // ==========================================================
   // 50 low, 10 high clocking pattern
   always_ff @(posedge clk) begin
      phase <= (phase == 6'h3B) ? 6'h00 : phase + 6'h01;
   end
   assign data_line_pin  = !data_low;
   assign clock_line_pin = !(clk_low || (clk_toggle && phase < 6'h32));
endmodule // smt_bus_agent
`default_nettype wire

/* bench/smt_timeout_detector_test.sv */
// testbench: timeout detector scenarios with register port
`timescale 1ns/10ps
`default_nettype none
module smt_timeout_detector_test
   import smt_pkg::*;
;
   logic clk, rst, ce, reg_wr, reg_rd, data_line_pin, clock_line_pin;
   logic master_mode, slave_mode, start_seen, stop_seen, ack_seen;
   logic in_byte, addr_match, transfer_done, addr_ack, bus_halt;
   logic transfer_irq_line, bus_error_irq, timeout_irq_line;
   logic data_low, clk_low, clk_toggle;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   int bad_count = 0;
   int comparisons = 0;
   smt_timeout_detector uut (.clk(clk), .rst(rst), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .data_line_pin(data_line_pin), .clock_line_pin(clock_line_pin),
      .master_mode(master_mode), .slave_mode(slave_mode),
      .start_seen(start_seen), .stop_seen(stop_seen), .ack_seen(ack_seen),
      .in_byte(in_byte), .addr_match(addr_match),
      .transfer_done(transfer_done), .addr_ack(addr_ack),
      .bus_halt(bus_halt), .transfer_irq_line(transfer_irq_line),
      .bus_error_irq(bus_error_irq), .timeout_irq_line(timeout_irq_line));
   smt_bus_agent agent (.clk(clk), .data_low(data_low), .clk_low(clk_low),
      .clk_toggle(clk_toggle), .data_line_pin(data_line_pin),
      .clock_line_pin(clock_line_pin));
   always #20 clk = !clk;
   // ==========================================================
   // register port, compare and closing tasks
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic close_out;
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_regs;
      logic [7:0] ex [8];
      ex = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};
      for (int i = 0; i < 8; i++) begin
         rd(4'(i), ex[i]);
      end
      wr(ADDR_CONTROL, 8'hFF);
      rd(ADDR_CONTROL, 8'h7F);
      for (int i = 2; i < 6; i++) begin
         wr(4'(i), 8'h00);
      end
      // enable low: the write must not land
      ce <= 1'b0;
      wr(ADDR_DATA_LIMIT, 8'h55);
      ce <= 1'b1;
      rd(ADDR_DATA_LIMIT, 8'h00);
   endtask
   task automatic t_ack;
      @(posedge clk);
      addr_match <= 1'b1;
      wr(ADDR_CONTROL, 8'h60);
      #1 chk({7'h00, addr_ack}, 8'h01);
      wr(ADDR_CONTROL, 8'h20);
      #1 chk({7'h00, addr_ack}, 8'h00);
      @(posedge clk);
      addr_match <= 1'b0;
   endtask
   task automatic t_err;
      @(posedge clk);
      master_mode <= 1'b1;
      stop_seen   <= 1'b1;
      @(posedge clk);
      master_mode <= 1'b0;
      stop_seen   <= 1'b0;
      #1 chk({7'h00, bus_halt}, 8'h01);
      rd(ADDR_BUS_CTRL, 8'h08);
      chk({7'h00, bus_error_irq}, 8'h00);
      wr(ADDR_BUS_CTRL, 8'h0C);
      #1 chk({7'h00, bus_error_irq}, 8'h01);
      wr(ADDR_BUS_CTRL, 8'h04);
      rd(ADDR_BUS_CTRL, 8'h04);
      @(posedge clk);
      in_byte    <= 1'b1;
      start_seen <= 1'b1;
      @(posedge clk);
      in_byte    <= 1'b0;
      start_seen <= 1'b0;
      #1 chk({7'h00, bus_halt}, 8'h01);
      chk({7'h00, bus_error_irq}, 8'h01);
      wr(ADDR_BUS_CTRL, 8'h00);
   endtask
   task automatic t_xfer;
      @(posedge clk);
      transfer_done <= 1'b1;
      @(posedge clk);
      transfer_done <= 1'b0;
      rd(ADDR_BUS_CTRL, 8'h01);
      chk({7'h00, transfer_irq_line}, 8'h00);
      wr(ADDR_BUS_CTRL, 8'h03);
      #1 chk({7'h00, transfer_irq_line}, 8'h01);
      wr(ADDR_BUS_CTRL, 8'h02);
      #1 chk({7'h00, transfer_irq_line}, 8'h00);
      @(posedge clk);
      transfer_done <= 1'b1;
      @(posedge clk);
      transfer_done <= 1'b0;
      #1 chk({7'h00, transfer_irq_line}, 8'h01);
      wr(ADDR_BUS_CTRL, 8'h00);
      rd(ADDR_BUS_CTRL, 8'h00);
   endtask
   // line kind k: 0 data low, 1 clock low, 2 clock pattern; m master,slave
   task automatic tmo(input logic [7:0] c, input logic [1:0] k,
                      input logic [1:0] m, input int n1, input int n2,
                      input logic [7:0] e);
      wr(ADDR_CONTROL, c);
      @(posedge clk);
      data_low    <= (k == 2'h0);
      clk_low     <= (k == 2'h1);
      clk_toggle  <= (k == 2'h2);
      master_mode <= m[1];
      slave_mode  <= m[0];
      repeat (n1) @(posedge clk);
      rd(ADDR_STATUS, 8'h00);
      repeat (n2) @(posedge clk);
      rd(ADDR_STATUS, e);
      chk({7'h00, timeout_irq_line}, {7'h00, c[4] && e != 8'h00});
      @(posedge clk);
      data_low    <= 1'b0;
      clk_low     <= 1'b0;
      clk_toggle  <= 1'b0;
      master_mode <= 1'b0;
      slave_mode  <= 1'b0;
      wr(ADDR_STATUS, 8'h0F);
      rd(ADDR_STATUS, e);
      wr(ADDR_STATUS, 8'h00);
      rd(ADDR_STATUS, 8'h00);
   endtask
   // master clock pattern with an ack every 61 cycles: no master flag
   task automatic t_mclr;
      wr(ADDR_CONTROL, 8'h21);
      @(posedge clk);
      clk_toggle  <= 1'b1;
      master_mode <= 1'b1;
      repeat (5) begin
         repeat (60) @(posedge clk);
         ack_seen <= 1'b1;
         @(posedge clk);
         ack_seen <= 1'b0;
      end
      rd(ADDR_STATUS, 8'h00);
      @(posedge clk);
      clk_toggle  <= 1'b0;
      master_mode <= 1'b0;
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      {clk, ce, rst} = 3'h7;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = 14'h0000;
      {master_mode, slave_mode, start_seen, stop_seen, ack_seen} = 5'h00;
      {in_byte, addr_match, transfer_done} = 3'h0;
      {data_low, clk_low, clk_toggle} = 3'h0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_ack;
      t_err;
      t_xfer;
      tmo(8'h29, 2'h0, 2'h0, 185, 30, 8'h08);
      tmo(8'h39, 2'h1, 2'h0, 185, 30, 8'h04);
      tmo(8'h3A, 2'h1, 2'h0, 385, 40, 8'h04);
      tmo(8'h38, 2'h1, 2'h0, 300, 100, 8'h00);
      tmo(8'h31, 2'h1, 2'h0, 300, 100, 8'h00);
      tmo(8'h31, 2'h1, 2'h2, 80, 40, 8'h02);
      tmo(8'h31, 2'h2, 2'h1, 170, 120, 8'h01);
      t_mclr;
      close_out;
   end
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      close_out;
   end
endmodule // smt_timeout_detector_test
bind smt_timeout_detector smt_props chk (.clk(clk), .rst(rst), .ce(ce),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_line_pin(data_line_pin),
   .clock_line_pin(clock_line_pin), .master_mode(master_mode),
   .slave_mode(slave_mode), .start_seen(start_seen), .stop_seen(stop_seen),
   .ack_seen(ack_seen), .in_byte(in_byte), .addr_match(addr_match),
   .transfer_done(transfer_done), .addr_ack(addr_ack), .bus_halt(bus_halt),
   .transfer_irq_line(transfer_irq_line), .bus_error_irq(bus_error_irq),
   .timeout_irq_line(timeout_irq_line));
`default_nettype wire
